// >>> hdl/dimmer_front_end.sv
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Slave only; never drives clock or conditions
// - Bits shift only on serial clock edges
// - Data line only pulled low or released
// - Transmitter holds data while clock high
// - Data change during clock high is condition
// - START is data fall, clock high
// - Ignore bus until START seen
// - STOP is data rise, clock high
// - Reset low initialises and holds defaults
// - Driver pins open drain, sink when lit
// - Each pin: on, off, blink one, two
// - Unused pins serve as general I/O
// - Address 1100 plus three select pins
// - Eighth bit: one read, zero write
// - Ack address match and written bytes
// - Read continues while master acks
module dimmer_front_end
	import dimmer_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic reset_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic addr_select_pin_0,
	input wire logic addr_select_pin_1,
	input wire logic addr_select_pin_2,
	input wire logic first_blink_source,
	input wire logic second_blink_source,
	input wire logic [31:0] pin_mode,
	input wire logic [7:0] tx_byte,
	output logic tx_take,
	output logic [7:0] rx_byte,
	output logic rx_valid,
	output logic [15:0] driver_pins_in,
	input wire logic [15:0] driver_pins_raw,
	output logic [15:0] driver_pins_out,
	output logic [15:0] driver_pins_oe_n
);
	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic scl_s, sda_s, rstn_s;
	logic [2:0] asel_s;
	logic [PIN_COUNT-1:0] pin_s;
	sync2 u_scl (.mclk(mclk), .rst(rst), .d(scl_in), .q(scl_s));
	sync2 u_sda (.mclk(mclk), .rst(rst), .d(sda_in), .q(sda_s));
	sync2 u_rstn (.mclk(mclk), .rst(rst), .d(reset_n), .q(rstn_s));
	sync2 u_a0 (.mclk(mclk), .rst(rst), .d(addr_select_pin_0), .q(asel_s[0]));
	sync2 u_a1 (.mclk(mclk), .rst(rst), .d(addr_select_pin_1), .q(asel_s[1]));
	sync2 u_a2 (.mclk(mclk), .rst(rst), .d(addr_select_pin_2), .q(asel_s[2]));
	genvar gi;
	generate
		for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
			sync2 u_p (.mclk(mclk), .rst(rst), .d(driver_pins_raw[gi]), .q(pin_s[gi]));
		end
	endgenerate

	// ----------------------------------------
	// Edge and condition detection
	// ----------------------------------------
	logic scl_p_q, sda_p_q;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			scl_p_q <= 1'h1;
			sda_p_q <= 1'h1;
		end else begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end
	logic scl_rise, scl_fall, start_det, stop_det;
	assign scl_rise = scl_s & ~scl_p_q;
	assign scl_fall = ~scl_s & scl_p_q;
	assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;

	// ----------------------------------------
	// Serial state machine
	// ----------------------------------------
	bus_st_t st_q, st_d;
	logic [7:0] sh_q, sh_d;
	logic [2:0] cnt_q, cnt_d;
	logic drv_q, drv_d, seen_q, seen_d;
	logic rxv_q, rxv_d, take_q, take_d;
	logic [7:0] rxb_q, rxb_d;
	always_comb begin
		st_d = st_q;
		sh_d = sh_q;
		cnt_d = cnt_q;
		drv_d = drv_q;
		rxv_d = 1'h0;
		take_d = 1'h0;
		rxb_d = rxb_q;
		seen_d = seen_q;
		if (!rstn_s) begin
			st_d = ST_IDLE;
			drv_d = 1'h0;
		end else if (stop_det) begin
			st_d = ST_IDLE;
			drv_d = 1'h0;
		end else if (start_det) begin
			st_d = ST_ADDR;
			cnt_d = BIT_FIRST;
			drv_d = 1'h0;
			seen_d = 1'h0;
		end else begin
			case (st_q)
				ST_IDLE: begin
					drv_d = 1'h0;
				end
				ST_ADDR: begin
					if (scl_rise) begin
						sh_d = {sh_q[6:0], sda_s};
						cnt_d = cnt_q + 3'h1;
						seen_d = 1'h1;
					end else if (scl_fall && cnt_q == BIT_FIRST && sh_q[7:4] == ADDR_FIXED
						&& sh_q[3:1] == asel_s && seen_q) begin
						st_d = ST_ADDR_ACK;
						drv_d = 1'h1;
					end else if (scl_fall && seen_q && cnt_q == BIT_FIRST) begin
						st_d = ST_WAIT;
					end
				end
				ST_ADDR_ACK: begin
					if (scl_fall) begin
						if (sh_q[0]) begin
							st_d = ST_RD;
							sh_d = tx_byte;
							take_d = 1'h1;
							drv_d = ~tx_byte[7];
							cnt_d = BIT_FIRST;
						end else begin
							st_d = ST_WR;
							drv_d = 1'h0;
							cnt_d = BIT_FIRST;
						end
					end
				end
				ST_WR: begin
					if (scl_rise) begin
						sh_d = {sh_q[6:0], sda_s};
						cnt_d = cnt_q + 3'h1;
					end else if (scl_fall && cnt_q == BIT_FIRST) begin
						st_d = ST_WR_ACK;
						drv_d = 1'h1;
						rxb_d = sh_q;
						rxv_d = 1'h1;
					end
				end
				ST_WR_ACK: begin
					if (scl_fall) begin
						st_d = ST_WR;
						drv_d = 1'h0;
					end
				end
				ST_RD: begin
					if (scl_fall) begin
						if (cnt_q == BIT_LAST) begin
							st_d = ST_RD_ACK;
							drv_d = 1'h0;
						end else begin
							sh_d = {sh_q[6:0], 1'h0};
							drv_d = ~sh_q[6];
						end
						cnt_d = cnt_q + 3'h1;
					end
				end
				ST_RD_ACK: begin
					if (scl_rise && sda_s) begin
						st_d = ST_WAIT;
					end else if (scl_fall) begin
						st_d = ST_RD;
						sh_d = tx_byte;
						take_d = 1'h1;
						drv_d = ~tx_byte[7];
						cnt_d = BIT_FIRST;
					end
				end
				ST_WAIT: begin
					drv_d = 1'h0;
				end
				default: begin
					st_d = ST_IDLE;
				end
			endcase
		end
	end
	// Serial state registers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_q <= ST_IDLE;
			sh_q <= '0;
			cnt_q <= BIT_FIRST;
			drv_q <= 1'h0;
			rxv_q <= 1'h0;
			take_q <= 1'h0;
			rxb_q <= '0;
			seen_q <= 1'h0;
		end else begin
			st_q <= st_d;
			sh_q <= sh_d;
			cnt_q <= cnt_d;
			drv_q <= drv_d;
			rxv_q <= rxv_d;
			take_q <= take_d;
			rxb_q <= rxb_d;
			seen_q <= seen_d;
		end
	end

	// ----------------------------------------
	// Serial data and driver pins
	// ----------------------------------------
	logic sda_pull;
	assign sda_pull = drv_q;
	assign sda_out = 1'h0;
	assign sda_oe_n = ~sda_pull;
	assign rx_byte = rxb_q;
	assign rx_valid = rxv_q;
	assign tx_take = take_q;
	assign driver_pins_in = pin_s;
	logic [PIN_COUNT-1:0] lit_q, lit_d;
	always_comb begin
		lit_d = lit_q;
		for (int i = 0; i < PIN_COUNT; i++) begin
			case (pin_mode[2*i +: 2])
				SEL_ON: lit_d[i] = 1'h1;
				SEL_BLINK_A: lit_d[i] = first_blink_source;
				SEL_BLINK_B: lit_d[i] = second_blink_source;
				default: lit_d[i] = 1'h0;
			endcase
		end
		if (!rstn_s) begin
			lit_d = '0;
		end
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			lit_q <= '0;
		end else begin
			lit_q <= lit_d;
		end
	end
	assign driver_pins_out = '0;
	assign driver_pins_oe_n = ~lit_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_start_addr: assert property (@(posedge mclk) disable iff (rst)
		(start_det && rstn_s && !stop_det) |=> st_q == ST_ADDR)
		else $error("start not taken");
	chk_stop_idle: assert property (@(posedge mclk) disable iff (rst)
		(stop_det && rstn_s) |=> st_q == ST_IDLE && !drv_q)
		else $error("stop did not idle");
	chk_idle_quiet: assert property (@(posedge mclk) disable iff (rst)
		st_q == ST_IDLE |-> sda_oe_n)
		else $error("drive while idle");
	chk_drive_low: assert property (@(posedge mclk) disable iff (rst)
		!sda_out && (sda_oe_n || st_q == ST_ADDR_ACK || st_q == ST_WR_ACK
		|| st_q == ST_RD))
		else $error("data driven high");
	chk_ack_write: assert property (@(posedge mclk) disable iff (rst)
		st_q == ST_WR_ACK |-> !sda_oe_n)
		else $error("no write ack");
	chk_ack_addr: assert property (@(posedge mclk) disable iff (rst)
		st_q == ST_ADDR_ACK |-> !sda_oe_n)
		else $error("no address ack");
	chk_nack_wait: assert property (@(posedge mclk) disable iff (rst)
		(st_q == ST_RD_ACK && scl_rise && sda_s && rstn_s && !start_det && !stop_det)
		|=> st_q == ST_WAIT)
		else $error("nack not honoured");
	chk_reset_hold: assert property (@(posedge mclk) disable iff (rst)
		!rstn_s |=> st_q == ST_IDLE && lit_q == '0)
		else $error("reset not held");
	chk_pin_on: assert property (@(posedge mclk) disable iff (rst)
		(pin_mode[1:0] == SEL_ON && rstn_s) |=> !driver_pins_oe_n[0])
		else $error("pin not lit");
endmodule
`default_nettype wire

// >>> hdl/dimmer_pkg.sv
package dimmer_pkg;
	// ----------------------------------------
	// Bus address and framing
	// ----------------------------------------
	localparam logic [3:0] ADDR_FIXED = 4'hC;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] BIT_FIRST = 3'h0;
	localparam int PIN_COUNT = 16;
	// ----------------------------------------
	// Pin behaviours
	// ----------------------------------------
	localparam logic [1:0] SEL_OFF = 2'h0;
	localparam logic [1:0] SEL_ON = 2'h1;
	localparam logic [1:0] SEL_BLINK_A = 2'h2;
	localparam logic [1:0] SEL_BLINK_B = 2'h3;
	typedef enum {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK, ST_WAIT} bus_st_t;
endpackage

// >>> hdl/sync2.sv
`timescale 1ns/100ps
`default_nettype none
module sync2 (
	input wire logic mclk,
	input wire logic rst,
	input wire logic d,
	output logic q
);
	logic s1_q;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s1_q <= 1'h1;
			q <= 1'h1;
		end else begin
			s1_q <= d;
			q <= s1_q;
		end
	end
endmodule
`default_nettype wire

// >>> tb/i2c_master_model.sv
`timescale 1ns/100ps
`default_nettype none
module i2c_master_model (
	output logic scl,
	output logic sda_pull,
	input wire logic sda
);
	localparam time Q = 8;
	// ----------------------------------------
	// Idle bus: clock stands high, data released
	// ----------------------------------------
	initial begin
		scl = 1'h1;
		sda_pull = 1'h0;
	end
	task automatic start();
		#Q sda_pull = 1'h0;
		#Q scl = 1'h1;
		#Q sda_pull = 1'h1;
		#Q scl = 1'h0;
	endtask
	task automatic stop();
		#Q sda_pull = 1'h1;
		#Q scl = 1'h1;
		#Q sda_pull = 1'h0;
		#Q;
	endtask
	// Data moves only while the clock is low
	task automatic wbit(input logic b, output logic r);
		#Q sda_pull = !b;
		#Q scl = 1'h1;
		#12 r = sda;
		#4 scl = 1'h0;
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) wbit(d[i], r);
		wbit(1'h1, r);
		ack = !r;
	endtask
	task automatic rbyte(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			wbit(1'h1, r);
			d[i] = r;
		end
		wbit(!ack, r);
	endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import dimmer_pkg::*;
	logic mclk = 1'h0, rst = 1'h1, reset_n = 1'h1, blink_a = 1'h0, blink_b = 1'h0;
	logic [2:0] sel = 3'h5;
	logic [31:0] pin_mode = 32'h0;
	logic [15:0] pins_raw = 16'h0;
	logic [15:0] pins_in, pins_out, pins_oe_n;
	logic [7:0] tx_byte, rx_byte, rx_last;
	logic sda_oe_n, sda_out, tx_take, rx_valid, scl, sda_pull;
	wire logic sda;
	int bad_count = 0, checked = 0, rx_cnt = 0, tx_cnt = 0;
	assign sda = !sda_pull & (sda_oe_n | sda_out);
	assign tx_byte = tx_cnt[0] ? 8'hC3 : 8'h5A;
	always #2 mclk = !mclk;
	always @(posedge mclk) begin
		if (rx_valid === 1'h1) begin
			rx_cnt <= rx_cnt + 1;
			rx_last <= rx_byte;
		end
		if (tx_take === 1'h1) tx_cnt <= tx_cnt + 1;
	end
	dimmer_front_end dut (.mclk(mclk), .rst(rst), .reset_n(reset_n), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_select_pin_0(sel[0]),
		.addr_select_pin_1(sel[1]), .addr_select_pin_2(sel[2]),
		.first_blink_source(blink_a), .second_blink_source(blink_b), .pin_mode(pin_mode),
		.tx_byte(tx_byte), .tx_take(tx_take), .rx_byte(rx_byte), .rx_valid(rx_valid),
		.driver_pins_in(pins_in), .driver_pins_raw(pins_raw), .driver_pins_out(pins_out),
		.driver_pins_oe_n(pins_oe_n));
	i2c_master_model m (.scl(scl), .sda_pull(sda_pull), .sda(sda));
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic results();
		$display("checked=%0d bad_count=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic t_write(input logic [7:0] d);
		logic ack;
		int n;
		n = rx_cnt;
		m.start();
		m.wbyte({ADDR_FIXED, sel, 1'h0}, ack);
		check(16'(ack), 16'h1);
		m.wbyte(d, ack);
		check(16'(ack), 16'h1);
		check(16'(rx_cnt - n), 16'h1);
		check({8'h0, rx_last}, {8'h0, d});
		m.stop();
		$display("test write done");
	endtask
	task automatic t_nomatch();
		logic ack;
		int n;
		n = rx_cnt;
		for (int k = 0; k < 2; k++) begin
			m.start();
			m.wbyte(k ? {ADDR_FIXED ^ 4'h1, sel, 1'h0} : {ADDR_FIXED, sel ^ 3'h1, 1'h0}, ack);
			check(16'(ack), 16'h0);
			m.wbyte(8'h33, ack);
			check(16'(ack), 16'h0);
			m.stop();
		end
		check(16'(rx_cnt - n), 16'h0);
		$display("test no match done");
	endtask
	task automatic t_read();
		logic ack;
		logic [7:0] d, e0, e1;
		int n;
		m.start();
		m.wbyte({ADDR_FIXED, sel, 1'h1}, ack);
		check(16'(ack), 16'h1);
		n = tx_cnt;
		e0 = n % 2 ? 8'hC3 : 8'h5A;
		e1 = n % 2 ? 8'h5A : 8'hC3;
		m.rbyte(1'h1, d);
		check({8'h0, d}, {8'h0, e0});
		m.rbyte(1'h0, d);
		check({8'h0, d}, {8'h0, e1});
		repeat (6) @(negedge mclk);
		check(16'(sda_oe_n), 16'h1);
		check(16'(tx_cnt - n), 16'h2);
		m.stop();
		$display("test read done");
	endtask
	task automatic t_abort();
		logic ack, r;
		int n;
		m.start();
		m.wbyte({ADDR_FIXED, sel, 1'h0}, ack);
		for (int i = 0; i < 4; i++) m.wbit(1'h1, r);
		n = rx_cnt;
		m.start();
		check(16'(rx_cnt - n), 16'h0);
		m.wbyte({ADDR_FIXED, sel, 1'h0}, ack);
		m.wbyte(8'h0F, ack);
		check({8'h0, rx_last}, 16'h000F);
		m.stop();
		$display("test abort done");
	endtask
	task automatic t_pins();
		for (int k = 0; k < 8; k++) begin
			@(negedge mclk);
			pin_mode = {16{2'(k % 4)}};
			blink_a = k < 4;
			blink_b = k >= 4;
			repeat (4) @(negedge mclk);
			check(pins_oe_n, (k % 4 == 1 || k == 2 || k == 7) ? 16'h0 : 16'hFFFF);
		end
		pins_raw = 16'hA55A;
		repeat (4) @(negedge mclk);
		check(pins_in, 16'hA55A);
		check(pins_out, 16'h0000);
		pin_mode = {16{SEL_ON}};
		reset_n = 1'h0;
		repeat (5) @(negedge mclk);
		check(pins_oe_n, 16'hFFFF);
		check(16'(sda_oe_n), 16'h1);
		reset_n = 1'h1;
		repeat (4) @(negedge mclk);
		$display("test pins done");
	endtask
	initial begin
		repeat (6) @(posedge mclk);
		@(negedge mclk) rst = 1'h0;
		check(16'(sda_oe_n), 16'h1);
		check(pins_oe_n, 16'hFFFF);
		repeat (4) @(negedge mclk);
		t_write(8'hA5);
		t_nomatch();
		t_read();
		t_abort();
		t_pins();
		t_write(8'h81);
		results();
	end
	initial begin
		#200000;
		bad_count++;
		results();
	end
endmodule
`default_nettype wire
